// *** hw/gpt_gpio_pin.sv ***
/*
  gpt_gpio_pin: one general-purpose pin with mode, pull, drive and
  alternate-function control, trigger interrupt and a pulse duration
  measurement timer, all behind an APB slave.
  Assumes: one clock at 200 MHz, synchronous active-high reset, an
  alternate peripheral on the same clock, pad logic that resolves
  pin_o/pin_oe and applies pull and drive selections.
  alt_o_i/alt_oe_i are taken unsynchronised, so they must share clk.
  Limitations: a start while the timer is busy is dropped; a limit of
  zero times out at the first tick; only whole prescaler ticks count,
  so a result may fall short by up to one microsecond.
*/
// Added by the designer: the APB interface to the registers and the register addresses.
// Summary of operation
// R1: input mode disables the driver, pin floats, level still sampled.
// R2: output mode drives the stored level onto the pin.
// R3: open-drain mode pulls low for 0, releases for 1.
// R4: alternate mode hands the pin to the peripheral.
// R5: alternate open-drain variant turns peripheral drive into open-drain.
// R6: pull choice is none, pull-up or pull-down.
// R7: supplied initial level applies only in output or open-drain mode.
// R8: drive strength is low, medium or high.
// R9: alternate selector picks a peripheral function in alternate modes.
// R10: a configuration write updates only the fields flagged as supplied.
// R11: leaving alternate mode for a gpio mode detaches the peripheral.
// R12: pulse level argument 0 times low pulses, 1 times high pulses.
// R13: wait for the target level unless matched, then time it.
// R14: result -2 on wait timeout, -1 on measure timeout, else micros.
// R15: one microsecond limit bounds both phases, default one million.
// R16: level written in input mode is held and shown once driving.
// R17: interrupt on falling, rising, low or high level, any combination.
// R18: microsecond tick from a prescaler; pin input synchronised first.
`timescale 1ns/1ps
`default_nettype none

module gpt_gpio_pin
  import gpt_pkg::*;
#(
  parameter logic [31:0] LIMIT_RESET = 32'(GPT_LIMIT_US)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pad
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe,
  output logic             pull_up_en,
  output logic             pull_down_en,
  output logic      [1:0]  drive_sel,
  // alternate peripheral
  input  wire logic        alt_o_i,
  input  wire logic        alt_oe_i,
  output logic             alt_en,
  output logic      [3:0]  alt_sel,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    gpt_mode_type        mode;
    gpt_pull_type        pull;
    gpt_drive_type       drive;
    logic [3:0]          alt_sel;
    logic                out_level;
    logic [3:0]          trig;
    logic [15:0]         presc;
    logic [31:0]         limit;
    gpt_pulse_state_type pstate;
    logic                plevel;
    logic [15:0]         pre_cnt;
    logic [31:0]         elapsed;
    logic [31:0]         result;
    logic [1:0]          istat;
    logic [1:0]          imask;
    logic [2:0]          sync;
    logic                pin_lvl;
    logic                src_prev;
    logic                pin_o;
    logic                pin_oe;
    logic                pull_up;
    logic                pull_dn;
    logic [1:0]          drv;
    logic                alt_en;
    logic [3:0]          alt_sel_o;
    logic                irq;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } gpt_state_type;

  gpt_state_type st_q;
  gpt_state_type st_d;

  // offsets that answer without a slave error
  function automatic logic gpt_mapped(input logic [7:0] a);
    unique case (a)
      GPT_OFS_CFG, GPT_OFS_OUT, GPT_OFS_IN, GPT_OFS_TRIG, GPT_OFS_PRESC,
      GPT_OFS_LIMIT, GPT_OFS_PCTRL, GPT_OFS_RESULT, GPT_OFS_ISTAT,
      GPT_OFS_IMASK: return 1'b1;
      default:       return 1'b0;
    endcase
  endfunction

  function automatic logic gpt_is_alt(input gpt_mode_type m);
    return (m == GPT_MODE_ALT) || (m == GPT_MODE_ALT_OPEN_DRAIN);
  endfunction

  // code 3 of the two-bit pull and drive fields has no meaning
  function automatic logic gpt_code2_ok(input logic [1:0] c);
    return c != 2'h3;
  endfunction

  function automatic logic gpt_expired(input logic [31:0] count,
                                       input logic [31:0] limit);
    return count >= limit;
  endfunction

  // unmapped offsets read as zero
  function automatic logic [31:0] gpt_read(input gpt_state_type s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      GPT_OFS_CFG: begin
        r[GPT_CFG_MODE_LSB +: 3]  = s.mode;
        r[GPT_CFG_PULL_LSB +: 2]  = s.pull;
        r[GPT_CFG_DRIVE_LSB +: 2] = s.drive;
        r[GPT_CFG_ALT_LSB +: 4]   = s.alt_sel;
        r[GPT_CFG_LEVEL_BIT]      = s.out_level;
      end
      GPT_OFS_OUT:    r[0] = s.out_level;
      GPT_OFS_IN: begin
        r[0] = s.pin_lvl;
        r[1] = s.pin_oe;
      end
      GPT_OFS_TRIG:   r[3:0] = s.trig;
      GPT_OFS_PRESC:  r[15:0] = s.presc;
      GPT_OFS_LIMIT:  r = s.limit;
      GPT_OFS_PCTRL: begin
        r[GPT_PCTRL_START] = (s.pstate != GPT_PT_IDLE);
        r[GPT_PCTRL_LEVEL] = s.plevel;
      end
      GPT_OFS_RESULT: r = s.result;
      GPT_OFS_ISTAT:  r[1:0] = s.istat;
      GPT_OFS_IMASK:  r[1:0] = s.imask;
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    logic        acc;
    logic        wr;
    logic        src;
    logic        evt;
    logic        match;
    logic        tick;
    logic        done;
    logic [31:0] next_el;
    logic [2:0]  mcode;
    logic [1:0]  pcode;
    logic [1:0]  dcode;
    acc     = psel && penable && !st_q.pready;
    wr      = psel && penable && st_q.pready && pwrite;
    src     = 1'b0;
    evt     = 1'b0;
    match   = 1'b0;
    tick    = 1'b0;
    done    = 1'b0;
    next_el = 32'h0000_0000;
    mcode   = pwdata[GPT_CFG_MODE_LSB +: 3];
    pcode   = pwdata[GPT_CFG_PULL_LSB +: 2];
    dcode   = pwdata[GPT_CFG_DRIVE_LSB +: 2];
    st_d    = st_q;

    // apb: one wait state, so prdata and pready both come from flops
    st_d.pready  = acc;
    st_d.pslverr = acc && !gpt_mapped(paddr);
    if (acc) begin
      st_d.prdata = gpt_read(st_q, paddr);
    end

    // three-stage input capture; accept a level once stages 2 and 3 agree
    st_d.sync = {st_q.sync[1:0], pin_i}; // see R18
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.pin_lvl = st_q.sync[2]; // see R1
    end

    if (wr) begin
      unique case (paddr)
        GPT_OFS_CFG: begin
          // absent fields keep their value
          if (pwdata[GPT_CFG_WR_MODE] && mcode <= 3'h4) begin // see R10
            st_d.mode = gpt_mode_type'(mcode);
          end
          if (pwdata[GPT_CFG_WR_PULL] && gpt_code2_ok(pcode)) begin // see R6
            st_d.pull = gpt_pull_type'(pcode);
          end
          if (pwdata[GPT_CFG_WR_DRIVE] && gpt_code2_ok(dcode)) begin // see R8
            st_d.drive = gpt_drive_type'(dcode);
          end
          if (pwdata[GPT_CFG_WR_ALT]) begin // see R9
            st_d.alt_sel = pwdata[GPT_CFG_ALT_LSB +: 4];
          end
          if (pwdata[GPT_CFG_WR_LEVEL] &&
              (st_d.mode == GPT_MODE_OUT ||
               st_d.mode == GPT_MODE_OPEN_DRAIN)) begin // see R7
            st_d.out_level = pwdata[GPT_CFG_LEVEL_BIT];
          end
        end
        // stored in any mode, driven only when an output mode is active
        GPT_OFS_OUT:   st_d.out_level = pwdata[0]; // see R16
        GPT_OFS_TRIG:  st_d.trig = pwdata[3:0];
        GPT_OFS_PRESC: st_d.presc = pwdata[15:0];
        GPT_OFS_LIMIT: st_d.limit = pwdata; // see R15
        GPT_OFS_IMASK: st_d.imask = pwdata[1:0];
        GPT_OFS_ISTAT: st_d.istat = st_q.istat & ~pwdata[1:0];
        default: ;
      endcase
    end

    // pin drive from the next mode so the pad follows the register
    st_d.alt_en    = gpt_is_alt(st_d.mode); // see R11
    st_d.alt_sel_o = st_d.alt_en ? st_d.alt_sel : GPT_ALT_RESET; // see R9
    st_d.pull_up   = (st_d.pull == GPT_PULL_UP); // see R6
    st_d.pull_dn   = (st_d.pull == GPT_PULL_DOWN);
    st_d.drv       = st_d.drive; // see R8
    unique case (st_d.mode)
      GPT_MODE_IN: begin
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = 1'b0; // see R1
      end
      GPT_MODE_OUT: begin
        st_d.pin_o  = st_d.out_level; // see R2
        st_d.pin_oe = 1'b1;
      end
      GPT_MODE_OPEN_DRAIN: begin
        st_d.pin_o  = 1'b0; // see R3
        st_d.pin_oe = !st_d.out_level;
      end
      GPT_MODE_ALT: begin
        st_d.pin_o  = alt_o_i; // see R4
        st_d.pin_oe = alt_oe_i;
      end
      GPT_MODE_ALT_OPEN_DRAIN: begin
        // peripheral can only pull low
        st_d.pin_o  = 1'b0; // see R5
        st_d.pin_oe = alt_oe_i && !alt_o_i;
      end
      default: begin
        // unassigned mode code: keep the pad released
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = 1'b0;
      end
    endcase

    // trigger source: the buffer while we drive it, the pin otherwise
    unique case (st_q.mode)
      GPT_MODE_OUT:        src = st_q.out_level;
      GPT_MODE_OPEN_DRAIN: src = st_q.out_level && st_q.pin_lvl;
      default:             src = st_q.pin_lvl;
    endcase
    st_d.src_prev = src;
    evt = (st_q.trig[GPT_TRIG_FALL] && st_q.src_prev && !src) ||
          (st_q.trig[GPT_TRIG_RISE] && !st_q.src_prev && src) ||
          (st_q.trig[GPT_TRIG_LOW] && !src) ||
          (st_q.trig[GPT_TRIG_HIGH] && src); // see R17

    // pulse timer
    match   = (st_q.pin_lvl == st_q.plevel);
    // >= so that lowering the prescaler mid-count never skips a wrap
    tick    = (st_q.pre_cnt >= st_q.presc);
    next_el = st_q.elapsed + 32'h0000_0001;
    if (st_q.pstate != GPT_PT_IDLE) begin
      st_d.pre_cnt = tick ? 16'h0000 : st_q.pre_cnt + 16'h0001; // see R18
    end
    unique case (st_q.pstate)
      GPT_PT_IDLE: begin
        // a start while busy is ignored; software polls the busy bit
        if (wr && paddr == GPT_OFS_PCTRL && pwdata[GPT_PCTRL_START]) begin
          st_d.plevel  = pwdata[GPT_PCTRL_LEVEL]; // see R12
          st_d.pre_cnt = 16'h0000;
          st_d.elapsed = 32'h0000_0000;
          st_d.pstate  = (st_q.pin_lvl == pwdata[GPT_PCTRL_LEVEL]) ?
                         GPT_PT_MEASURE : GPT_PT_WAIT; // see R13
        end
      end
      GPT_PT_WAIT: begin
        if (match) begin
          st_d.pstate  = GPT_PT_MEASURE; // see R13
          st_d.pre_cnt = 16'h0000;
          st_d.elapsed = 32'h0000_0000;
        end else if (tick) begin
          if (gpt_expired(next_el, st_q.limit)) begin // see R15
            st_d.result = GPT_RES_WAIT_TO; // see R14
            st_d.pstate = GPT_PT_IDLE;
            done        = 1'b1;
          end else begin
            st_d.elapsed = next_el;
          end
        end
      end
      GPT_PT_MEASURE: begin
        if (!match) begin
          st_d.result = st_q.elapsed; // see R14
          st_d.pstate = GPT_PT_IDLE;
          done        = 1'b1;
        end else if (tick) begin
          if (gpt_expired(next_el, st_q.limit)) begin // see R15
            st_d.result = GPT_RES_MEAS_TO; // see R14
            st_d.pstate = GPT_PT_IDLE;
            done        = 1'b1;
          end else begin
            st_d.elapsed = next_el;
          end
        end
      end
      default: begin
        // unreachable code: fall back to idle rather than lock up
        st_d.pstate = GPT_PT_IDLE;
      end
    endcase

    // sticky status, a new event wins over a same-cycle clear
    if (evt) begin
      st_d.istat[GPT_IRQ_PIN] = 1'b1;
    end
    if (done) begin
      st_d.istat[GPT_IRQ_PULSE] = 1'b1;
    end
    st_d.irq = |(st_d.istat & st_d.imask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // fields not named below reset to zero
      st_q           <= '0;
      st_q.mode      <= GPT_MODE_IN;
      st_q.pull      <= GPT_PULL_NONE;
      st_q.drive     <= GPT_DRIVE_LOW;
      st_q.alt_sel   <= GPT_ALT_RESET;
      st_q.trig      <= GPT_TRIG_RESET;
      st_q.presc     <= GPT_PRESC_RESET;
      st_q.limit     <= LIMIT_RESET;
      st_q.pstate    <= GPT_PT_IDLE;
      st_q.imask     <= GPT_MASK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata       = st_q.prdata;
  assign pready       = st_q.pready;
  assign pslverr      = st_q.pslverr;
  assign pin_o        = st_q.pin_o;
  assign pin_oe       = st_q.pin_oe;
  assign pull_up_en   = st_q.pull_up;
  assign pull_down_en = st_q.pull_dn;
  assign drive_sel    = st_q.drv;
  assign alt_en       = st_q.alt_en;
  assign alt_sel      = st_q.alt_sel_o;
  assign irq          = st_q.irq;

endmodule

`default_nettype wire

// *** hw/gpt_pkg.sv ***
/*
  gpt_pkg: shared constants and types for the single-pin gpio controller
  with pulse timer. Assumes a 200 MHz system clock and an APB register bus
  with 32-bit data and byte addresses on 8 bits.
*/
package gpt_pkg;

  // register byte offsets
  localparam logic [7:0] GPT_OFS_CFG    = 8'h00;
  localparam logic [7:0] GPT_OFS_OUT    = 8'h04;
  localparam logic [7:0] GPT_OFS_IN     = 8'h08;
  localparam logic [7:0] GPT_OFS_TRIG   = 8'h0C;
  localparam logic [7:0] GPT_OFS_PRESC  = 8'h10;
  localparam logic [7:0] GPT_OFS_LIMIT  = 8'h14;
  localparam logic [7:0] GPT_OFS_PCTRL  = 8'h18;
  localparam logic [7:0] GPT_OFS_RESULT = 8'h1C;
  localparam logic [7:0] GPT_OFS_ISTAT  = 8'h20;
  localparam logic [7:0] GPT_OFS_IMASK  = 8'h24;

  // configuration register fields
  localparam int GPT_CFG_MODE_LSB  = 0;
  localparam int GPT_CFG_PULL_LSB  = 4;
  localparam int GPT_CFG_DRIVE_LSB = 8;
  localparam int GPT_CFG_ALT_LSB   = 12;
  localparam int GPT_CFG_LEVEL_BIT = 16;
  localparam int GPT_CFG_WR_MODE   = 24;
  localparam int GPT_CFG_WR_PULL   = 25;
  localparam int GPT_CFG_WR_DRIVE  = 26;
  localparam int GPT_CFG_WR_LEVEL  = 27;
  localparam int GPT_CFG_WR_ALT    = 28;

  // trigger enable bits
  localparam int GPT_TRIG_FALL = 0;
  localparam int GPT_TRIG_RISE = 1;
  localparam int GPT_TRIG_LOW  = 2;
  localparam int GPT_TRIG_HIGH = 3;

  // pulse control and interrupt bits
  localparam int GPT_PCTRL_START = 0;
  localparam int GPT_PCTRL_LEVEL = 1;
  localparam int GPT_IRQ_PIN     = 0;
  localparam int GPT_IRQ_PULSE   = 1;

  // timing
  localparam int          GPT_CLK_HZ      = 200000000;
  localparam int          GPT_TICK_US     = 1;
  localparam logic [15:0] GPT_PRESC_RESET =
    16'(GPT_CLK_HZ / 1000000 * GPT_TICK_US - 1);
  localparam int          GPT_LIMIT_US    = 1000000;

  // reported results
  localparam logic [31:0] GPT_RES_WAIT_TO = 32'hFFFF_FFFE;
  localparam logic [31:0] GPT_RES_MEAS_TO = 32'hFFFF_FFFF;

  // reset values
  localparam logic [3:0] GPT_ALT_RESET  = 4'h0;
  localparam logic [3:0] GPT_TRIG_RESET = 4'h0;
  localparam logic [1:0] GPT_MASK_RESET = 2'h0;

  typedef enum logic [2:0] {
    GPT_MODE_IN, GPT_MODE_OUT, GPT_MODE_OPEN_DRAIN, GPT_MODE_ALT,
    GPT_MODE_ALT_OPEN_DRAIN
  } gpt_mode_type;
  typedef enum logic [1:0] {GPT_PULL_NONE, GPT_PULL_UP, GPT_PULL_DOWN}
    gpt_pull_type;
  typedef enum logic [1:0] {GPT_DRIVE_LOW, GPT_MEDIUM_DRIVE_LEVEL,
    GPT_DRIVE_HIGH} gpt_drive_type;
  typedef enum logic [1:0] {GPT_PT_IDLE, GPT_PT_WAIT, GPT_PT_MEASURE}
    gpt_pulse_state_type;

endpackage

// *** sim/gpt_gpio_pin_sva.sv ***
/*
  gpt_gpio_pin_sva: port checker for gpt_gpio_pin, bound below.
  Assumes the design's apb one-wait-state timing and registered pad outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module gpt_gpio_pin_sva
  import gpt_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pad and peripheral
  input wire logic        pin_oe,
  input wire logic        pull_up_en,
  input wire logic        pull_down_en,
  input wire logic [1:0]  drive_sel,
  input wire logic        alt_oe_i,
  input wire logic        alt_en,
  input wire logic [3:0]  alt_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] drv_q;
  always_ff @(posedge clk)
    if (pready && pwrite && paddr == GPT_OFS_CFG) drv_q <= pwdata[9:8];
  a_ready_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("late answer");
  a_err_unmapped: assert property (
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h24))
    else $error("wrong error flag");
  a_pull_exclusive: assert property (
    !(pull_up_en && pull_down_en)) else $error("both pulls on");
  a_drive_legal: assert property (
    drive_sel != 2'h3) else $error("illegal drive code");
  a_drive_update: assert property (
    pready && pwrite && paddr == GPT_OFS_CFG && pwdata[26] &&
    pwdata[9:8] != 2'h3 |-> ##[1:2] drive_sel == drv_q)
    else $error("drive not applied");
  a_cfg_stable: assert property (
    pready && pwrite && paddr != GPT_OFS_CFG |=>
    $stable({pull_up_en, pull_down_en, drive_sel}) [*2])
    else $error("config moved");
  a_alt_release: assert property (
    alt_en && $past(alt_en) && !$past(alt_oe_i) |-> !pin_oe)
    else $error("pin driven without peripheral");
  a_sel_detach: assert property (
    !alt_en |-> alt_sel == 4'h0) else $error("selector left attached");
endmodule

bind gpt_gpio_pin gpt_gpio_pin_sva i_gpt_gpio_pin_sva (.clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .pin_oe,
  .pull_up_en, .pull_down_en, .drive_sel, .alt_oe_i, .alt_en, .alt_sel);

`default_nettype wire

// *** sim/gpt_gpio_pin_tb_top.sv ***
/*
  gpt_gpio_pin_tb_top: self-checking bench for gpt_gpio_pin.
  Assumes gpt_pin_partner on the pad and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin tests_run++; if ((a) !== (e)) begin \
  mismatches++; $display("mismatch at %0t: got %h", $time, a); end end

module gpt_gpio_pin_tb_top;
  import gpt_pkg::*;
  localparam logic [31:0] LIM = 32'h14;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, pin_i, pin_o, pin_oe, pull_up_en, irq;
  logic        pull_down_en, alt_en, ext_en = 0, ext_val = 0;
  logic        alt_o_i = 0, alt_oe_i = 0;
  logic [1:0]  drive_sel;
  logic [3:0]  alt_sel;
  logic [64:0] e;
  logic [64:0] exp_q[$];
  int          mismatches = 0, tests_run = 0, cyc = 0;

  gpt_gpio_pin #(.LIMIT_RESET(LIM)) i_gpt_gpio_pin (.clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_i,
    .pin_o, .pin_oe, .pull_up_en, .pull_down_en, .drive_sel, .alt_o_i,
    .alt_oe_i, .alt_en, .alt_sel, .irq);
  gpt_pin_partner i_gpt_pin_partner (.clk, .pin_o, .pin_oe, .pull_up_en,
    .pull_down_en, .ext_en, .ext_val, .pin_level(pin_i));

  initial forever #2.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // extra edge at the end so a following request never reassigns psel
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // mask 0 reads fetch rv and check only pslverr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] d, input logic er);
    exp_q.push_back({er, m, d});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic wait_done();
    repeat (60) begin
      rd(GPT_OFS_PCTRL, 32'h0, 32'h0, 1'b0);
      if (rv[0] === 1'b0) break;
    end
  endtask

  function automatic logic [31:0] cf(input logic [4:0] f,
      input gpt_mode_type m, input logic [1:0] p, input logic [1:0] dr,
      input logic [3:0] s, input logic lv);
    return {3'h0, f, 7'h0, lv, s, 2'h0, dr, 2'h0, p, 1'h0, m};
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end else if (pready === 1'b1 && psel && !pwrite) begin
      e = exp_q.pop_front();
      rv = prdata;
      `chk(prdata & e[63:32], e[31:0])
      `chk(pslverr, e[64])
    end
  end

  initial begin : main
    int ao;
    void'($urandom(32'h2DCBB2B5));
    idle(8);
    reset <= 1'b0;
    idle(1);
    rd(GPT_OFS_PRESC, ALL, 32'(GPT_PRESC_RESET), 1'b0);
    rd(GPT_OFS_LIMIT, ALL, LIM, 1'b0);
    rd(GPT_OFS_IMASK, ALL, 32'h0, 1'b0);
    rd(8'h28, ALL, 32'h0, 1'b1);
    $display("test reset done");
    ext_en <= 1'b1;
    wr(GPT_OFS_OUT, 32'h1);
    idle(4);
    `chk(pin_oe, 1'b0)
    rd(GPT_OFS_IN, 32'h3, 32'h0, 1'b0);
    ext_en <= 1'b0;
    wr(GPT_OFS_CFG, cf(5'h01, GPT_MODE_OUT, 2'h0, 2'h0, 4'h0, 1'b0));
    idle(4);
    `chk({pin_oe, pin_o}, 2'h3)
    rd(GPT_OFS_IN, 32'h3, 32'h3, 1'b0);
    wr(GPT_OFS_CFG, cf(5'h09, GPT_MODE_OPEN_DRAIN, 2'h0, 2'h0, 4'h0, 1'b0));
    idle(2);
    `chk({pin_oe, pin_o}, 2'h2)
    wr(GPT_OFS_CFG, cf(5'h08, GPT_MODE_IN, 2'h0, 2'h0, 4'h0, 1'b1));
    idle(2);
    `chk(pin_oe, 1'b0)
    wr(GPT_OFS_CFG, cf(5'h09, GPT_MODE_IN, 2'h0, 2'h0, 4'h0, 1'b0));
    wr(GPT_OFS_CFG, cf(5'h01, GPT_MODE_OUT, 2'h0, 2'h0, 4'h0, 1'b0));
    idle(2);
    `chk({pin_oe, pin_o}, 2'h3)
    $display("test modes done");
    for (int p = 0; p < 3; p++) begin
      for (int d = 0; d < 3; d++) begin
        wr(GPT_OFS_CFG, cf(5'h06, GPT_MODE_IN, 2'(p), 2'(d), 4'h0, 1'b0));
        idle(2);
        `chk({pull_up_en, pull_down_en}, {p == 1, p == 2})
        `chk(drive_sel, 2'(d))
        `chk(pin_oe, 1'b1)
      end
    end
    wr(GPT_OFS_CFG, cf(5'h07, gpt_mode_type'(3'h7), 2'h3, 2'h3, 4'h0, 1'b0));
    idle(2);
    `chk({pull_up_en, pull_down_en, drive_sel, pin_oe}, 5'h0D)
    alt_oe_i <= 1'b1;
    wr(GPT_OFS_CFG, cf(5'h10, GPT_MODE_IN, 2'h0, 2'h0, 4'h7, 1'b0));
    idle(2);
    `chk(alt_sel, 4'h0)
    wr(GPT_OFS_CFG, cf(5'h11, GPT_MODE_ALT, 2'h0, 2'h0, 4'h5, 1'b0));
    for (int i = 0; i < 4; i++) begin
      ao = $urandom;
      alt_o_i <= ao[0];
      alt_oe_i <= 1'(i % 2);
      idle(3);
      `chk({alt_en, alt_sel, pin_oe, pin_o}, {5'h15, alt_oe_i, ao[0]})
    end
    wr(GPT_OFS_CFG,
       cf(5'h01, GPT_MODE_ALT_OPEN_DRAIN, 2'h0, 2'h0, 4'h0, 1'b0));
    for (int v = 0; v < 2; v++) begin
      alt_o_i <= 1'(v);
      idle(3);
      `chk(pin_oe, 1'(v == 0))
    end
    wr(GPT_OFS_CFG, cf(5'h01, GPT_MODE_IN, 2'h0, 2'h0, 4'h0, 1'b0));
    idle(2);
    `chk({alt_en, alt_sel, pin_oe}, 6'h00)
    $display("test config done");
    ext_en <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      wr(GPT_OFS_TRIG, 32'h0);
      ext_val <= ~t[0];
      idle(6);
      wr(GPT_OFS_ISTAT, 32'h3);
      wr(GPT_OFS_TRIG, 32'h1 << t);
      rd(GPT_OFS_ISTAT, 32'h1, 32'h0, 1'b0);
      ext_val <= t[0];
      idle(6);
      rd(GPT_OFS_ISTAT, 32'h1, 32'h1, 1'b0);
      `chk(irq, 1'b0)
      wr(GPT_OFS_IMASK, 32'h1);
      idle(2);
      `chk(irq, 1'b1)
      wr(GPT_OFS_IMASK, 32'h0);
    end
    wr(GPT_OFS_TRIG, 32'h0);
    $display("test trigger done");
    wr(GPT_OFS_PRESC, 32'h1);
    ext_val <= 1'b1;
    idle(6);
    wr(GPT_OFS_PCTRL, 32'h3);
    wait_done();
    rd(GPT_OFS_RESULT, ALL, GPT_RES_MEAS_TO, 1'b0);
    ext_val <= 1'b0;
    idle(6);
    wr(GPT_OFS_PCTRL, 32'h3);
    wait_done();
    rd(GPT_OFS_RESULT, ALL, GPT_RES_WAIT_TO, 1'b0);
    ext_val <= 1'b1;
    idle(6);
    wr(GPT_OFS_ISTAT, 32'h3);
    wr(GPT_OFS_PCTRL, 32'h1);
    ao = $urandom_range(10, 4);
    idle(ao);
    ext_val <= 1'b0;
    idle(12);
    ext_val <= 1'b1;
    wait_done();
    rd(GPT_OFS_RESULT, 32'h0, 32'h0, 1'b0);
    `chk(rv >= 5 && rv <= 7, 1'b1)
    rd(GPT_OFS_ISTAT, 32'h2, 32'h2, 1'b0);
    $display("test pulse done");
    tally_and_finish();
  end
endmodule

`default_nettype wire

// *** sim/gpt_pin_partner.sv ***
/*
  gpt_pin_partner: the circuit wired to the pin.
  Assumes pad outputs of gpt_gpio_pin and a source driven by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module gpt_pin_partner (
  // pad
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  // external source and resolved level
  input  wire logic ext_en,
  input  wire logic ext_val,
  output var  logic pin_level
);
  logic last_q = 1'b0;
  always_comb
    if (pin_oe) pin_level = pin_o;
    else if (ext_en) pin_level = ext_val;
    else if (pull_up_en) pin_level = 1'b1;
    else if (pull_down_en) pin_level = 1'b0;
    else pin_level = ~last_q;  // floating: never the stale value
  // remember only a driven or pulled level, so a float stays put
  always_ff @(posedge clk)
    if (pin_oe || ext_en || pull_up_en || pull_down_en) last_q <= pin_level;
endmodule

`default_nettype wire
